//--- hdl/clkbuf_regs.svh
// register map and fixed values of the clock buffer control bank
// assumes inclusion by bare name from the design files
`ifndef CLKBUF_REGS_SVH
`define CLKBUF_REGS_SVH

`define CLKBUF_TARGET_ADDR    7'h6A
`define CLKBUF_OFS_LVDS_OE    8'h00
`define CLKBUF_OFS_DIV_A      8'h01
`define CLKBUF_OFS_DIV_B      8'h02
`define CLKBUF_OFS_RSVD3      8'h03
`define CLKBUF_OFS_RSVD4      8'h04
`define CLKBUF_OFS_RSVD5      8'h05
`define CLKBUF_OFS_IDENT      8'h06
`define CLKBUF_REG_COUNT      8'h07
`define CLKBUF_BIT_OE_THIRD   5
`define CLKBUF_BIT_OE_FOURTH  4
`define CLKBUF_RST_OE_THIRD   1'b1
`define CLKBUF_RST_OE_FOURTH  1'b1
`define CLKBUF_RST_DIV_A      8'h0F
`define CLKBUF_RST_DIV_B      8'h2E
`define CLKBUF_DIV_MIN        8'h02

`endif

//--- hdl/clkbuf_pkg.sv
// types shared by the clock buffer control bank
// assumes no other package
package clkbuf_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_DEV_ACK,
    ST_SEND,
    ST_HOST_ACK
  } serial_state_e;

  typedef logic [7:0] byte_t;

endpackage

//--- hdl/power_clock_divider.sv
// divides the reference tick into one power-control clock
// assumes ref_tick_i is a one-cycle pulse on clock_i at the reference rate
`timescale 1ns/10ps
`include "clkbuf_regs.svh"

module power_clock_divider #(
  parameter logic [7:0] RESET_DIVIDE = `CLKBUF_RST_DIV_A
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ce_i,
  input  wire logic       ref_tick_i,
  input  wire logic [7:0] divide_i,
  output logic            clk_o
);

  logic [7:0] active_div;
  logic [7:0] count;
  wire        period_end = (count >= active_div - 8'h01);
  wire  [7:0] next_count = period_end ? 8'h00 : count + 8'h01;
  wire  [7:0] high_len   = active_div >> 1;
  wire        running    = (active_div >= `CLKBUF_DIV_MIN);

  // new divider taken only at a period boundary, but that tick uses the old value: a stop leaves a one-tick pulse, a start a short one [R14]
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      active_div <= RESET_DIVIDE;
      count      <= 8'h00;
      clk_o      <= 1'b0;
    end else if (ce_i && ref_tick_i) begin
      count <= next_count;
      clk_o <= running && (next_count < high_len); // [R14]
      if (period_end) begin
        active_div <= divide_i;
      end
    end
  end

endmodule // power_clock_divider

//--- hdl/clock_buffer_i2c_control_regs.sv
// serial target register bank of the clock buffer
// assumes scl/sda are raw pins; ref_tick_i comes from clock_i-domain logic
// Contract
// (R1) target only; block write and read
// (R2) answers fixed seven-bit address, D4/D5
// (R3) first byte after write address is offset
// (R4) byte0 bit5 enables third lvds, resets 1
// (R5) byte0 bit4 enables fourth lvds, resets 1
// (R6) byte1 divider for clock a, reset 0x0F
// (R7) byte2 divider for clock b, reset 0x2E
// (R8) bytes 3 to 5 reserved, read-only
// (R9) byte6 read-only revision and vendor ident
// (R10) write: offset, count, data; device acks each
// (R11) read: count then data; host nacks last
// (R12) disabled lvds pair is not driven
// (R13) offset advances per data byte; ro ignored
// (R14) dividers glitch-free at reference over value; stopping one emits a one-tick pulse
`timescale 1ns/10ps
`include "clkbuf_regs.svh"

module clock_buffer_i2c_control_regs #(
  parameter logic [3:0] REVISION_ID = 4'h3, // value arbitrary
  parameter logic [3:0] VENDOR_ID   = 4'h5  // value arbitrary
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  input  wire logic ref_tick_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      lvds_clock_third_oe_o,
  output logic      lvds_clock_fourth_oe_o,
  output logic      power_clock_out_a_o,
  output logic      power_clock_out_b_o
);

  clkbuf_pkg::serial_state_e state;
  logic [2:0]          scl_sync;
  logic [2:0]          sda_sync;
  logic                scl_f;
  logic                sda_f;
  logic                scl_q;
  logic                sda_q;
  logic [3:0]          bit_cnt;
  logic [1:0]          byte_idx;
  logic                is_read;
  logic                host_ack;
  clkbuf_pkg::byte_t   shreg;
  clkbuf_pkg::byte_t   tx;
  clkbuf_pkg::byte_t   pointer;
  logic                oe_third;
  logic                oe_fourth;
  clkbuf_pkg::byte_t   div_a;
  clkbuf_pkg::byte_t   div_b;

  // three-stage synchronisers, level changes once stages two and three agree
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else if (ce_i) begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise  = scl_f & ~scl_q;
  wire scl_fall  = ~scl_f & scl_q;
  wire start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_det  = scl_f & scl_q & ~sda_q & sda_f;

  // rx byte completes with the eighth bit shifted in
  wire [7:0] rx_byte    = shreg;
  wire       addr_match = (rx_byte[7:1] == `CLKBUF_TARGET_ADDR); // [R2]

  // read decode; reserved bits and locations read as zero [R8]
  wire [7:0] lvds_oe_byte = ({7'h00, oe_third} << `CLKBUF_BIT_OE_THIRD)
                          | ({7'h00, oe_fourth} << `CLKBUF_BIT_OE_FOURTH);
  wire [7:0] read_byte =
      (pointer == `CLKBUF_OFS_LVDS_OE) ? lvds_oe_byte :
      (pointer == `CLKBUF_OFS_DIV_A)   ? div_a :
      (pointer == `CLKBUF_OFS_DIV_B)   ? div_b :
      (pointer == `CLKBUF_OFS_IDENT)   ? {REVISION_ID, VENDOR_ID} : // [R9]
                                         8'h00;

  wire wr_data = (byte_idx == 2'd3);
  wire wr_oe   = wr_data && (pointer == `CLKBUF_OFS_LVDS_OE);
  wire wr_div_a = wr_data && (pointer == `CLKBUF_OFS_DIV_A);
  wire wr_div_b = wr_data && (pointer == `CLKBUF_OFS_DIV_B);
  wire [7:0] count_byte = `CLKBUF_REG_COUNT;

  // target-only sequencer: never drives scl, only answers the host [R1]
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state    <= clkbuf_pkg::ST_IDLE;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'd0;
      is_read  <= 1'b0;
      host_ack <= 1'b0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      pointer  <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else if (ce_i) begin
      sda_o <= 1'b0;
      if (start_det) begin
        state    <= clkbuf_pkg::ST_RECV;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'd0;
        sda_oe_o <= 1'b0;
      end else if (stop_det) begin
        state    <= clkbuf_pkg::ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        unique case (state)
          clkbuf_pkg::ST_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          clkbuf_pkg::ST_RECV: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (byte_idx == 2'd0) begin
                if (addr_match) begin
                  is_read  <= rx_byte[0];
                  sda_oe_o <= 1'b1; // [R10]
                  state    <= clkbuf_pkg::ST_DEV_ACK;
                end else begin
                  state <= clkbuf_pkg::ST_IDLE;
                end
              end else begin
                if (byte_idx == 2'd1) begin
                  pointer <= rx_byte; // [R3]
                end else if (wr_data) begin
                  pointer <= pointer + 8'h01; // [R13]
                end
                sda_oe_o <= 1'b1; // [R10]
                state    <= clkbuf_pkg::ST_DEV_ACK;
              end
              if (byte_idx != 2'd3) begin
                byte_idx <= byte_idx + 2'd1;
              end
            end
          end
          clkbuf_pkg::ST_DEV_ACK: begin
            if (scl_fall) begin
              if (is_read) begin
                // count byte goes out first [R11]
                tx       <= count_byte;
                sda_oe_o <= ~count_byte[7];
                state    <= clkbuf_pkg::ST_SEND;
              end else begin
                sda_oe_o <= 1'b0;
                state    <= clkbuf_pkg::ST_RECV;
              end
            end
          end
          clkbuf_pkg::ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                bit_cnt  <= 4'h0;
                sda_oe_o <= 1'b0;
                state    <= clkbuf_pkg::ST_HOST_ACK;
              end else begin
                bit_cnt  <= bit_cnt + 4'h1;
                tx       <= {tx[6:0], 1'b0};
                sda_oe_o <= ~tx[6];
              end
            end
          end
          clkbuf_pkg::ST_HOST_ACK: begin
            if (scl_rise) begin
              host_ack <= ~sda_f;
            end else if (scl_fall) begin
              if (host_ack) begin
                tx       <= read_byte;
                sda_oe_o <= ~read_byte[7];
                pointer  <= pointer + 8'h01; // [R13]
                state    <= clkbuf_pkg::ST_SEND;
              end else begin
                state <= clkbuf_pkg::ST_IDLE; // [R11]
              end
            end
          end
        endcase
      end
    end
  end

  // register writes; read-only and reserved offsets drop the data [R13]
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      oe_third  <= `CLKBUF_RST_OE_THIRD;  // [R4]
      oe_fourth <= `CLKBUF_RST_OE_FOURTH; // [R5]
      div_a     <= `CLKBUF_RST_DIV_A;     // [R6]
      div_b     <= `CLKBUF_RST_DIV_B;     // [R7]
    end else if (ce_i && state == clkbuf_pkg::ST_RECV && scl_fall && bit_cnt == 4'h8) begin
      if (wr_oe) begin
        oe_third  <= rx_byte[`CLKBUF_BIT_OE_THIRD];  // [R4]
        oe_fourth <= rx_byte[`CLKBUF_BIT_OE_FOURTH]; // [R5]
      end
      if (wr_div_a) begin
        div_a <= rx_byte; // [R6]
      end
      if (wr_div_b) begin
        div_b <= rx_byte; // [R7]
      end
    end
  end

  // pad drivers tri-state the pair while low [R12]
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lvds_clock_third_oe_o  <= `CLKBUF_RST_OE_THIRD;
      lvds_clock_fourth_oe_o <= `CLKBUF_RST_OE_FOURTH;
    end else if (ce_i) begin
      lvds_clock_third_oe_o  <= oe_third;  // [R12]
      lvds_clock_fourth_oe_o <= oe_fourth; // [R12]
    end
  end

  power_clock_divider #(
    .RESET_DIVIDE (`CLKBUF_RST_DIV_A)
  ) u_div_a (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .ref_tick_i (ref_tick_i),
    .divide_i   (div_a),
    .clk_o      (power_clock_out_a_o)
  );

  power_clock_divider #(
    .RESET_DIVIDE (`CLKBUF_RST_DIV_B)
  ) u_div_b (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .ce_i       (ce_i),
    .ref_tick_i (ref_tick_i),
    .divide_i   (div_b),
    .clk_o      (power_clock_out_b_o)
  );

endmodule // clock_buffer_i2c_control_regs

//--- sim/clkbuf_chk.sv
// port assertions of the clock buffer control bank
// assumes bind onto the bank's top module
`timescale 1ns/10ps
module clkbuf_chk (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic ref_tick_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic lvds_clock_third_oe_o,
  input wire logic lvds_clock_fourth_oe_o,
  input wire logic power_clock_out_a_o,
  input wire logic power_clock_out_b_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_scl_high;
    scl_i [*6];
  endsequence
  sequence s_pull_run;
    sda_oe_o [*8];
  endsequence
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  a_rst_oe_on: assert property (@(posedge clock_i) disable iff (1'b0)
    sys_rst_i |=> lvds_clock_third_oe_o && lvds_clock_fourth_oe_o)
    else $error("lvds enables not set by reset");
  a_rst_pclk_low: assert property (@(posedge clock_i) disable iff (1'b0)
    sys_rst_i |=> !power_clock_out_a_o && !power_clock_out_b_o)
    else $error("power clocks not low in reset");
  a_pull_after_fall: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("sda pulled outside scl low");
  a_pull_stands_high: assert property (s_scl_high |-> $stable(sda_oe_o))
    else $error("sda drive changed while scl high");
  a_pull_min_len: assert property ($rose(sda_oe_o) |=> s_pull_run)
    else $error("sda drive too short");
  a_pclk_on_tick: assert property ($changed(power_clock_out_a_o) ||
    $changed(power_clock_out_b_o) |-> $past(ref_tick_i) || $past(ref_tick_i, 2))
    else $error("power clock moved without reference tick");
  a_oe_at_write: assert property ($changed(lvds_clock_third_oe_o) ||
    $changed(lvds_clock_fourth_oe_o) |-> ##[0:3] sda_oe_o)
    else $error("lvds enable changed outside a data ack");
  a_ce_freeze: assert property (!ce_i |=> $stable(sda_oe_o) && $stable(power_clock_out_a_o))
    else $error("state moved with clock enable low");
endmodule // clkbuf_chk

bind clock_buffer_i2c_control_regs clkbuf_chk u_chk (.clock_i, .sys_rst_i, .ce_i, .ref_tick_i,
  .scl_i, .sda_o, .sda_oe_o, .lvds_clock_third_oe_o, .lvds_clock_fourth_oe_o,
  .power_clock_out_a_o, .power_clock_out_b_o);

//--- sim/i2c_host_model.sv
// serial bus host: start, nine-bit units, stop
// assumes sda_i is the resolved wire with a pull-up
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  int hp = 10;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // start or repeated start
  task automatic sta();
    wt(3);
    sda_pull_o = 1'b0;
    wt(hp);
    scl_o = 1'b1;
    wt(hp);
    sda_pull_o = 1'b1;
    wt(hp);
    scl_o = 1'b0;
  endtask
  task automatic sto();
    wt(3);
    sda_pull_o = 1'b1;
    wt(hp);
    scl_o = 1'b1;
    wt(hp);
    sda_pull_o = 1'b0;
    wt(hp);
  endtask
  // byte msb first, then ack bit
  task automatic xb(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      wt(3);
      sda_pull_o = !d[i];
      wt(hp);
      scl_o = 1'b1;
      wt(hp);
      r[i] = sda_i;
      scl_o = 1'b0;
    end
  endtask
endmodule // i2c_host_model

//--- sim/tb_top.sv
// self-checking bench of the clock buffer control bank
// assumes the host model owns the serial pins
`timescale 1ns/10ps
module tb_top;
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       ce_i = 1'b1;
  logic       ref_tick_i = 1'b0;
  logic       scl, pull, sda_oe_o, sda_o, oe3, oe4, pa, pb;
  logic [7:0] q[$], got, d1, d2;
  logic [8:0] r;
  int         n_mismatch = 0, checks = 0, nt = 0, tc = 0, seed = 32'h4EED;
  event       ev;
  wire        sda = !(pull | sda_oe_o);
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    #1;
    tc = (tc + 1) % 10;
    ref_tick_i = (tc == 0);
    nt += ref_tick_i;
  end
  clock_buffer_i2c_control_regs DUT (.clock_i, .sys_rst_i, .ce_i, .ref_tick_i,
    .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_o, .lvds_clock_third_oe_o(oe3),
    .lvds_clock_fourth_oe_o(oe4), .power_clock_out_a_o(pa), .power_clock_out_b_o(pb));
  i2c_host_model host (.clock_i, .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  task automatic summarize();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  initial forever begin
    @ev;
    chk("read byte", got, q.pop_front());
  end
  task automatic wr(input logic [7:0] b[$], input logic e);
    host.sta();
    foreach (b[i]) begin
      host.xb({b[i], 1'b1}, r);
      chk("ack", {7'h00, r[0]}, {7'h00, e});
    end
    host.sto();
  endtask
  task automatic rd(input logic [7:0] o, input int n);
    host.sta();
    host.xb({8'hD4, 1'b1}, r);
    host.xb({o, 1'b1}, r);
    host.sta();
    host.xb({8'hD5, 1'b1}, r);
    chk("read ack", {7'h00, r[0]}, 8'h00);
    for (int i = 0; i <= n; i++) begin
      host.xb({8'hFF, i == n}, r);
      got = r[8:1];
      ->ev;
    end
    host.sto();
  endtask
  task automatic meas(input logic s, input logic [7:0] e);
    int t;
    @(posedge (s ? pb : pa));
    t = nt;
    @(posedge (s ? pb : pa));
    chk("period", 8'(nt - t), e);
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    host.wt(5);
    chk("oe third", {7'h00, oe3}, 8'h01);
    chk("oe fourth", {7'h00, oe4}, 8'h01);
    q = {8'h07, 8'h30, 8'h0F, 8'h2E, 8'h00, 8'h00, 8'h00, 8'h35};
    rd(8'h00, 7);
    meas(1'b0, 8'h0F);
    meas(1'b1, 8'h2E);
    d1 = 8'(8'h02 + ($random(seed) & 32'h1F));
    d2 = 8'(8'h02 + ($random(seed) & 32'h1F));
    wr({8'hD4, 8'h00, 8'h07, 8'h00, d1, d2, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 1'b0);
    chk("oe third off", {7'h00, oe3}, 8'h00);
    chk("oe fourth off", {7'h00, oe4}, 8'h00);
    host.hp = 16;
    q = {8'h07, 8'h00, d1, d2, 8'h00, 8'h00, 8'h00, 8'h35};
    rd(8'h00, 7);
    host.hp = 10;
    meas(1'b0, d1);
    meas(1'b1, d2);
    wr({8'hD4, 8'h00, 8'h01, 8'h20}, 1'b0);
    chk("oe third on", {7'h00, oe3}, 8'h01);
    wr({8'hD6, 8'h00, 8'h01, 8'h10}, 1'b1);
    chk("oe fourth kept", {7'h00, oe4}, 8'h00);
    // frozen long enough that a running divider would have toggled
    ce_i = 1'b0;
    host.wt(400);
    ce_i = 1'b1;
    sys_rst_i = 1'b1;
    host.wt(2);
    sys_rst_i = 1'b0;
    host.wt(5);
    q = {8'h07, 8'h0F};
    rd(8'h01, 1);
    // divide value 1 stops the clock once the running period ends
    wr({8'hD4, 8'h01, 8'h01, 8'h01}, 1'b0);
    host.wt(300);
    repeat (40) begin
      host.wt(10);
      chk("clock off", {7'h00, pa}, 8'h00);
    end
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    summarize();
  end
endmodule // tb_top
